// >>> rtl/wait_thresh_pkg.sv
`default_nettype none
package wait_thresh_pkg;

   // Register offsets on the internal register port
   localparam logic [7:0] PAUSE_LENGTH_ADDR        = 8'h83;
   localparam logic [7:0] LIGHT_LOW_LIMIT_LO_ADDR  = 8'h84;
   localparam logic [7:0] LIGHT_LOW_LIMIT_HI_ADDR  = 8'h85;
   localparam logic [7:0] LIGHT_HIGH_LIMIT_LO_ADDR = 8'h86;
   localparam logic [7:0] LIGHT_HIGH_LIMIT_HI_ADDR = 8'h87;
   localparam logic [7:0] NEAR_LOW_LIMIT_LO_ADDR   = 8'h88;
   localparam logic [7:0] NEAR_LOW_LIMIT_HI_ADDR   = 8'h89;

   // Reset values
   localparam logic [7:0] PAUSE_LENGTH_RESET = 8'h00;
   localparam logic [7:0] LIMIT_BYTE_RESET   = 8'h00;
   localparam logic [7:0] UNMAPPED_READ      = 8'h00;

   // Field positions
   localparam int AUTOREG_OFF_BIT  = 6;
   localparam int NEAR_HI_FIELD_MSB = 5;
   localparam int NEAR_COARSE_LSB  = 2;

   // Timing
   localparam int STEP_TIME_NS    = 2780000;
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int STEP_CYCLES     = STEP_TIME_NS / CLOCK_PERIOD_NS;
   localparam int EXTEND_FACTOR   = 12;

   // Persistence count width and light persistence table knee
   localparam int PERSIST_W       = 6;
   localparam logic [3:0] LIGHT_LINEAR_LAST = 4'h3;
   localparam logic [5:0] LIGHT_STEP        = 6'h05;

   typedef enum logic {PAUSE_IDLE, PAUSE_RUN} pause_state_t;

   // Light persistence code to required consecutive out-of-range count
   function automatic logic [5:0] light_persist_count(input logic [3:0] code);
      logic [5:0] span;
      span = {2'h0, code} - {2'h0, LIGHT_LINEAR_LAST};
      if (code <= LIGHT_LINEAR_LAST)
         light_persist_count = {2'h0, code};
      else
         light_persist_count = 6'(span * LIGHT_STEP);
   endfunction : light_persist_count

endpackage : wait_thresh_pkg
`default_nettype wire

// >>> rtl/pause_timer.sv
`default_nettype none
module pause_timer #(
   parameter int STEP_CYCLES = wait_thresh_pkg::STEP_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       start,
   input  wire logic       extend,
   input  wire logic [7:0] length,
   output logic            busy,
   output logic            done
);
   localparam int LONG_CYCLES = STEP_CYCLES * wait_thresh_pkg::EXTEND_FACTOR;
   localparam int PW          = $clog2(LONG_CYCLES + 1);

   if (STEP_CYCLES < 1)
      $error("pause_timer: STEP_CYCLES must be at least one");

   wait_thresh_pkg::pause_state_t state_reg;
   logic [PW-1:0] presc_reg;
   logic [7:0]    count_reg;
   logic          extend_reg;
   logic          done_reg;
   wire  [PW-1:0] step_last = extend_reg ? PW'(LONG_CYCLES - 1) : PW'(STEP_CYCLES - 1);
   wire           tick      = (presc_reg == step_last);

   // Down counter of steps; a step is twelve times longer while extended
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg  <= wait_thresh_pkg::PAUSE_IDLE;
         presc_reg  <= '0;
         count_reg  <= 8'h00;
         extend_reg <= 1'b0;
         done_reg   <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         case (state_reg)
            wait_thresh_pkg::PAUSE_IDLE:
               if (start)
               begin
                  state_reg  <= wait_thresh_pkg::PAUSE_RUN;
                  count_reg  <= length;
                  extend_reg <= extend;
                  presc_reg  <= '0;
               end
            wait_thresh_pkg::PAUSE_RUN:
               if (tick)
               begin
                  presc_reg <= '0;
                  if (count_reg == 8'h00)
                  begin
                     state_reg <= wait_thresh_pkg::PAUSE_IDLE;
                     done_reg  <= 1'b1;
                  end
                  else
                     count_reg <= count_reg - 8'h01;
               end
               else
                  presc_reg <= presc_reg + PW'(1);
            default: state_reg <= wait_thresh_pkg::PAUSE_IDLE;
         endcase
      end
   end

   assign busy = (state_reg == wait_thresh_pkg::PAUSE_RUN);
   assign done = done_reg;
endmodule : pause_timer
`default_nettype wire

// >>> rtl/persist_filter.sv
`default_nettype none
module persist_filter (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       sample_valid,
   input  wire logic       outside,
   input  wire logic [5:0] required,
   output logic            fire
);
   logic [5:0] count_reg;
   logic       fire_reg;
   wire  [5:0] count_inc = (count_reg == required) ? count_reg : count_reg + 6'h01;

   // Saturate at the target so every further outside result fires too
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= 6'h00;
         fire_reg  <= 1'b0;
      end
      else
      begin
         fire_reg <= 1'b0;
         if (sample_valid)
         begin
            if (required == 6'h00)
               fire_reg <= 1'b1;
            else if (outside)
            begin
               count_reg <= count_inc;
               fire_reg  <= (count_inc == required);
            end
            else
               count_reg <= 6'h00;
         end
      end
   end

   assign fire = fire_reg;
endmodule : persist_filter
`default_nettype wire

// >>> rtl/wait_and_threshold_regs.sv
`default_nettype none
module wait_and_threshold_regs #(
   parameter int STEP_CYCLES = wait_thresh_pkg::STEP_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Internal register port behind the serial engine
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   output logic             reg_rvalid,
   // Settings held in neighbouring registers
   input  wire logic        wait_enable,
   input  wire logic        pause_extend_x12,
   input  wire logic [7:0]  config_six_register,
   input  wire logic [3:0]  light_persistence,
   input  wire logic [3:0]  near_persistence,
   input  wire logic        light_irq_enable,
   input  wire logic        near_irq_enable,
   input  wire logic [13:0] near_high_limit,
   // Measurement engine
   input  wire logic        cycle_done,
   input  wire logic [15:0] clear_result,
   input  wire logic        clear_valid,
   input  wire logic [13:0] near_result,
   input  wire logic        near_valid,
   input  wire logic        light_flag_clear,
   input  wire logic        near_flag_clear,
   output logic             pause_active,
   output logic             pause_done,
   output logic             light_threshold_flag,
   output logic             near_threshold_flag,
   output logic             irq_n
);

   if (STEP_CYCLES < 1)
      $error("wait_and_threshold_regs: STEP_CYCLES must be at least one");

   // Register storage
   logic [7:0]  pause_length_reg;
   logic [7:0]  light_low_shadow_reg;
   logic [15:0] light_low_live_reg;
   logic [7:0]  light_high_shadow_reg;
   logic [15:0] light_high_live_reg;
   logic [7:0]  near_low_shadow_reg;
   logic [7:0]  near_low_hi_reg;
   logic [13:0] near_low_live_reg;
   logic [7:0]  reg_rdata_reg;
   logic        reg_rvalid_reg;
   logic        light_flag_reg;
   logic        near_flag_reg;
   logic        irq_n_reg;
   logic        skip_done_reg;

   // Address decode
   wire hit_pause      = (reg_addr == wait_thresh_pkg::PAUSE_LENGTH_ADDR);
   wire hit_light_l_lo = (reg_addr == wait_thresh_pkg::LIGHT_LOW_LIMIT_LO_ADDR);
   wire hit_light_l_hi = (reg_addr == wait_thresh_pkg::LIGHT_LOW_LIMIT_HI_ADDR);
   wire hit_light_h_lo = (reg_addr == wait_thresh_pkg::LIGHT_HIGH_LIMIT_LO_ADDR);
   wire hit_light_h_hi = (reg_addr == wait_thresh_pkg::LIGHT_HIGH_LIMIT_HI_ADDR);
   wire hit_near_l_lo  = (reg_addr == wait_thresh_pkg::NEAR_LOW_LIMIT_LO_ADDR);
   wire hit_near_l_hi  = (reg_addr == wait_thresh_pkg::NEAR_LOW_LIMIT_HI_ADDR);

   // Read selection; low bytes read back the shadow as the host wrote it
   wire [7:0] read_mux =
      hit_pause      ? pause_length_reg :
      hit_light_l_lo ? light_low_shadow_reg :
      hit_light_l_hi ? light_low_live_reg[15:8] :
      hit_light_h_lo ? light_high_shadow_reg :
      hit_light_h_hi ? light_high_live_reg[15:8] :
      hit_near_l_lo  ? near_low_shadow_reg :
      hit_near_l_hi  ? near_low_hi_reg :
      wait_thresh_pkg::UNMAPPED_READ;

   // Pause length register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         pause_length_reg <= wait_thresh_pkg::PAUSE_LENGTH_RESET;
      else if (reg_wr && hit_pause)
         pause_length_reg <= reg_wdata;
   end

   // Light low limit: low byte waits in the shadow until the high byte lands
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         light_low_shadow_reg <= wait_thresh_pkg::LIMIT_BYTE_RESET;
         light_low_live_reg   <= {2{wait_thresh_pkg::LIMIT_BYTE_RESET}};
      end
      else if (reg_wr && hit_light_l_lo)
         light_low_shadow_reg <= reg_wdata;
      else if (reg_wr && hit_light_l_hi)
         light_low_live_reg <= {reg_wdata, light_low_shadow_reg};
   end

   // Light high limit, same shadow scheme so a half update never compares
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         light_high_shadow_reg <= wait_thresh_pkg::LIMIT_BYTE_RESET;
         light_high_live_reg   <= {2{wait_thresh_pkg::LIMIT_BYTE_RESET}};
      end
      else if (reg_wr && hit_light_h_lo)
         light_high_shadow_reg <= reg_wdata;
      else if (reg_wr && hit_light_h_hi)
         light_high_live_reg <= {reg_wdata, light_high_shadow_reg};
   end

   // Near low limit; upper byte keeps all eight bits for readback only
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         near_low_shadow_reg <= wait_thresh_pkg::LIMIT_BYTE_RESET;
         near_low_hi_reg     <= wait_thresh_pkg::LIMIT_BYTE_RESET;
         near_low_live_reg   <= 14'h0000;
      end
      else if (reg_wr && hit_near_l_lo)
         near_low_shadow_reg <= reg_wdata;
      else if (reg_wr && hit_near_l_hi)
      begin
         near_low_hi_reg   <= reg_wdata;
         near_low_live_reg <= {reg_wdata[wait_thresh_pkg::NEAR_HI_FIELD_MSB:0],
                               near_low_shadow_reg};
      end
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata_reg  <= 8'h00;
         reg_rvalid_reg <= 1'b0;
      end
      else
      begin
         reg_rvalid_reg <= reg_rd;
         if (reg_rd)
            reg_rdata_reg <= read_mux;
      end
   end

   // Threshold compares
   wire autoreg_off  = config_six_register[wait_thresh_pkg::AUTOREG_OFF_BIT];
   wire light_below  = (clear_result < light_low_live_reg);
   wire light_above  = (clear_result > light_high_live_reg);
   wire light_out    = light_below || light_above;
   // With autoregulation off the upper byte is ignored, so the live low byte
   // is taken straight from the shadow; no second write is needed then
   wire [7:0] near_coarse = near_result[wait_thresh_pkg::NEAR_COARSE_LSB +: 8];
   wire near_below_fine   = (near_result < near_low_live_reg);
   wire near_below_coarse = (near_coarse < near_low_shadow_reg);
   wire near_above_fine   = (near_result > near_high_limit);
   wire near_above_coarse = (near_coarse > near_high_limit[7:0]);
   wire near_below        = autoreg_off ? near_below_coarse : near_below_fine;
   wire near_above        = autoreg_off ? near_above_coarse : near_above_fine;
   wire near_out          = near_below || near_above;

   // Persistence targets
   wire [5:0] light_required = wait_thresh_pkg::light_persist_count(light_persistence);
   wire [5:0] near_required  = {2'h0, near_persistence};
   wire       light_fire;
   wire       near_fire;

   persist_filter light_persist (
      .clock        (clock),
      .rst_n        (rst_n),
      .sample_valid (clear_valid),
      .outside      (light_out),
      .required     (light_required),
      .fire         (light_fire)
   );

   persist_filter near_persist (
      .clock        (clock),
      .rst_n        (rst_n),
      .sample_valid (near_valid),
      .outside      (near_out),
      .required     (near_required),
      .fire         (near_fire)
   );

   // Sticky flags; a set in the clearing cycle wins over the clear
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         light_flag_reg <= 1'b0;
         near_flag_reg  <= 1'b0;
      end
      else
      begin
         light_flag_reg <= light_fire || (light_flag_reg && !light_flag_clear);
         near_flag_reg  <= near_fire || (near_flag_reg && !near_flag_clear);
      end
   end

   // Interrupt pin, active low, registered so it never glitches
   wire irq_active = (light_flag_reg && light_irq_enable) ||
                     (near_flag_reg && near_irq_enable);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         irq_n_reg <= 1'b1;
      else
         irq_n_reg <= !irq_active;
   end

   // Pause sequencing: start only with the wait feature on, else skip at once
   wire timer_start = cycle_done && wait_enable;
   wire timer_busy;
   wire timer_done;

   pause_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) pause_step_timer (
      .clock  (clock),
      .rst_n  (rst_n),
      .start  (timer_start),
      .extend (pause_extend_x12),
      .length (pause_length_reg),
      .busy   (timer_busy),
      .done   (timer_done)
   );

   // Skipped pause reports done one cycle later, same latency as a start
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         skip_done_reg <= 1'b0;
      else
         skip_done_reg <= cycle_done && !wait_enable;
   end

   // Outputs
   assign reg_rdata            = reg_rdata_reg;
   assign reg_rvalid           = reg_rvalid_reg;
   assign pause_active         = timer_busy;
   assign pause_done           = timer_done || skip_done_reg;
   assign light_threshold_flag = light_flag_reg;
   assign near_threshold_flag  = near_flag_reg;
   assign irq_n                = irq_n_reg;

endmodule : wait_and_threshold_regs
`default_nettype wire

// >>> dv/wait_and_threshold_regs_asserts.sv
`default_nettype none
module wait_and_threshold_regs_asserts #(
   parameter int STEP_CYCLES = 4
) (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       wait_enable,
   input wire logic       pause_extend_x12,
   input wire logic [3:0] light_persistence,
   input wire logic       light_irq_enable,
   input wire logic       near_irq_enable,
   input wire logic       cycle_done,
   input wire logic       clear_valid,
   input wire logic       light_flag_clear,
   input wire logic       pause_active,
   input wire logic       pause_done,
   input wire logic       light_threshold_flag,
   input wire logic       near_threshold_flag,
   input wire logic       irq_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [7:0] len_reg;
   logic [7:0] run_len_reg;
   logic       run_ext_reg;
   logic       run_wait_reg;
   int         run_cnt_reg;
   wire        start = cycle_done && !pause_active;
   wire        cause = (light_threshold_flag && light_irq_enable) || (near_threshold_flag && near_irq_enable);
   int         run_exp;
   // Expected pause span in cycles, twelve times longer while extended
   assign run_exp = (int'(run_len_reg) + 1) * STEP_CYCLES * (run_ext_reg ? 12 : 1);
   // Mirror the pause length from bus writes; the count is judged at done
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         len_reg      <= 8'h00;
         run_len_reg  <= 8'h00;
         run_ext_reg  <= 1'b0;
         run_wait_reg <= 1'b0;
         run_cnt_reg  <= 0;
      end
      else
      begin
         if (reg_wr && reg_addr == wait_thresh_pkg::PAUSE_LENGTH_ADDR)
            len_reg <= reg_wdata;
         if (start)
         begin
            run_len_reg  <= len_reg;
            run_ext_reg  <= pause_extend_x12;
            run_wait_reg <= wait_enable;
            run_cnt_reg  <= 0;
         end
         else if (pause_active)
            run_cnt_reg <= run_cnt_reg + 1;
      end

   property p_irq_light; light_threshold_flag && light_irq_enable |=> !irq_n; endproperty
   a_irq_light: assert property (p_irq_light) else $error("light flag did not pull the pin");
   property p_irq_near; near_threshold_flag && near_irq_enable |=> !irq_n; endproperty
   a_irq_near: assert property (p_irq_near) else $error("near flag did not pull the pin");
   property p_irq_quiet; !cause |=> irq_n; endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("pin active without cause");
   property p_pause_go; start && wait_enable |=> pause_active; endproperty
   a_pause_go: assert property (p_pause_go) else $error("pause did not start");
   property p_pause_skip; start && !wait_enable |=> pause_done && !pause_active; endproperty
   a_pause_skip: assert property (p_pause_skip) else $error("pause inserted while disabled");
   property p_pause_len; pause_done && run_wait_reg |-> run_cnt_reg == run_exp; endproperty
   a_pause_len: assert property (p_pause_len) else $error("pause length wrong");
   property p_done_once; pause_done |=> !pause_done && !pause_active; endproperty
   a_done_once: assert property (p_done_once) else $error("pause end not a single pulse");
   property p_light_every; clear_valid && light_persistence == 4'h0 |-> ##2 light_threshold_flag; endproperty
   a_light_every: assert property (p_light_every) else $error("zero persistence did not set flag");
   property p_flag_hold; light_threshold_flag && !light_flag_clear |=> light_threshold_flag; endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("light flag dropped uncleared");
endmodule : wait_and_threshold_regs_asserts

bind wait_and_threshold_regs wait_and_threshold_regs_asserts #(.STEP_CYCLES(STEP_CYCLES)) chk (
   .clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .wait_enable, .pause_extend_x12,
   .light_persistence, .light_irq_enable, .near_irq_enable, .cycle_done, .clear_valid,
   .light_flag_clear, .pause_active, .pause_done, .light_threshold_flag, .near_threshold_flag, .irq_n
);
`default_nettype wire

// >>> dv/host_model.sv
`default_nettype none
module host_model (
   input  wire logic       clock,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // Released lines show the inverse so stale values are never trusted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock) #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr

   // Answer is valid in the cycle after the strobe was taken
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clock) #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock) #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
   endtask : rd

   // Limit pair: low byte first, upper byte straight after
   task automatic limit(input logic [7:0] lo_addr, input logic [15:0] v);
      wr(lo_addr, v[7:0]);
      wr(lo_addr + 8'h01, lo_addr == 8'h88 ? {2'b00, v[13:8]} : v[15:8]);
   endtask : limit
endmodule : host_model
`default_nettype wire

// >>> dv/tb_wait_and_threshold_regs.sv
`default_nettype none
module tb_wait_and_threshold_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STEP = 4;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd, reg_rvalid;
   logic        wait_enable = 1'b0;
   logic        pause_extend_x12 = 1'b0;
   logic [7:0]  config_six_register = 8'h00;
   logic [3:0]  light_persistence = 4'h1;
   logic [3:0]  near_persistence = 4'h1;
   logic        light_irq_enable = 1'b0;
   logic        near_irq_enable = 1'b0;
   logic        cycle_done = 1'b0;
   logic [15:0] clear_result = 16'h0000;
   logic        clear_valid = 1'b0;
   logic [13:0] near_result = 14'h0000;
   logic        near_valid = 1'b0;
   logic        flag_clear = 1'b0;
   logic        pause_active, pause_done, light_threshold_flag, near_threshold_flag, irq_n;
   int          err_count = 0;
   int          cmp_count = 0;

   always #20 clock = ~clock;

   host_model host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid);

   wait_and_threshold_regs #(.STEP_CYCLES(STEP)) dut (
      .clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
      .wait_enable, .pause_extend_x12, .config_six_register, .light_persistence, .near_persistence,
      .light_irq_enable, .near_irq_enable, .near_high_limit(14'h3FFF), .cycle_done, .clear_result,
      .clear_valid, .near_result, .near_valid, .light_flag_clear(flag_clear), .near_flag_clear(flag_clear),
      .pause_active, .pause_done, .light_threshold_flag, .near_threshold_flag, .irq_n
   );

   task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_val

   task automatic give_verdict();
      if (err_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      host.rd(a, d, v);
      cmp_val(d, exp);
      cmp_val({7'h00, v}, 8'h01);
   endtask : rd_chk

   // One sample, valid held for exactly one cycle
   task automatic sample(input logic near, input logic [15:0] val);
      @(posedge clock) #1;
      near_result = val[13:0];
      clear_result = val;
      near_valid = near;
      clear_valid = !near;
      @(posedge clock) #1;
      near_valid = 1'b0;
      clear_valid = 1'b0;
   endtask : sample

   // Flag has settled two edges after the sample was taken
   task automatic chk(input logic near, input logic exp);
      repeat (2) @(posedge clock);
      #1;
      cmp_val({7'h00, near ? near_threshold_flag : light_threshold_flag}, {7'h00, exp});
   endtask : chk

   task automatic clr();
      @(posedge clock) #1;
      flag_clear = 1'b1;
      @(posedge clock) #1;
      flag_clear = 1'b0;
   endtask : clr

   task automatic t_regs();
      for (int a = 8'h83; a <= 8'h89; a++)
         rd_chk(8'(a), 8'h00);
      host.wr(8'h8A, 8'hFF);
      rd_chk(8'h8A, 8'h00);
      host.wr(8'h83, 8'h5A);
      rd_chk(8'h83, 8'h5A);
   endtask : t_regs

   // A lone low-byte write must stay in the shadow until the high byte lands
   task automatic t_light();
      host.limit(8'h86, 16'hFFFF);
      host.limit(8'h84, 16'h55AA);
      rd_chk(8'h84, 8'hAA);
      clr();
      sample(1'b0, 16'h55AA);
      chk(1'b0, 1'b0);
      sample(1'b0, 16'h55A9);
      chk(1'b0, 1'b1);
      clr();
      host.wr(8'h84, 8'hAB);
      sample(1'b0, 16'h55AA);
      chk(1'b0, 1'b0);
      host.wr(8'h85, 8'h55);
      sample(1'b0, 16'h55AA);
      chk(1'b0, 1'b1);
      host.limit(8'h84, 16'h0000);
      host.limit(8'h86, 16'h1234);
      clr();
      sample(1'b0, 16'h1234);
      chk(1'b0, 1'b0);
      light_irq_enable = 1'b1;
      sample(1'b0, 16'h1235);
      chk(1'b0, 1'b1);
      cmp_val({7'h00, irq_n}, 8'h00);
      light_irq_enable = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      cmp_val({7'h00, irq_n}, 8'h01);
   endtask : t_light

   task automatic t_near();
      near_irq_enable = 1'b1;
      host.limit(8'h88, 16'h0234);
      clr();
      sample(1'b1, 16'h0234);
      chk(1'b1, 1'b0);
      sample(1'b1, 16'h0233);
      chk(1'b1, 1'b1);
      cmp_val({7'h00, irq_n}, 8'h00);
      config_six_register = 8'h40;
      clr();
      sample(1'b1, 16'h00D0);
      chk(1'b1, 1'b0);
      sample(1'b1, 16'h00CF);
      chk(1'b1, 1'b1);
      config_six_register = 8'h00;
      near_irq_enable = 1'b0;
   endtask : t_near

   // Inside results restart the run, so the flag waits for n fresh outside ones
   task automatic persist(input logic near, input logic [3:0] code, input int n);
      light_persistence = near ? 4'h1 : code;
      near_persistence = near ? code : 4'h1;
      sample(near, 16'h2000);
      repeat (n - 1) sample(near, 16'h0010);
      sample(near, 16'h2000);
      clr();
      repeat (n - 1) sample(near, 16'h0010);
      chk(near, 1'b0);
      sample(near, 16'h0010);
      chk(near, 1'b1);
   endtask : persist

   task automatic t_persist();
      logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
      int         counts [6] = '{1, 2, 3, 5, 10, 60};
      host.limit(8'h84, 16'h1000);
      host.limit(8'h86, 16'hFFFF);
      host.limit(8'h88, 16'h0100);
      foreach (codes[i])
         persist(1'b0, codes[i], counts[i]);
      foreach (codes[i])
         persist(1'b1, codes[i], int'(codes[i]));
      light_persistence = 4'h0;
      near_persistence = 4'h0;
      clr();
      sample(1'b0, 16'h2000);
      chk(1'b0, 1'b1);
      sample(1'b1, 16'h2000);
      chk(1'b1, 1'b1);
   endtask : t_persist

   // Cycles from the taken cycle_done to the pause_done pulse
   task automatic pause(input logic en, input logic ext, input logic [7:0] len);
      int n = 0;
      int exp;
      host.wr(8'h83, len);
      wait_enable = en;
      pause_extend_x12 = ext;
      exp = en ? (int'(len) + 1) * STEP * (ext ? 12 : 1) : 0;
      @(posedge clock) #1;
      cycle_done = 1'b1;
      @(posedge clock) #1;
      cycle_done = 1'b0;
      cmp_val({7'h00, pause_active}, {7'h00, en});
      while (pause_done !== 1'b1 && n < 2000)
      begin
         @(posedge clock) #1;
         n++;
      end
      cmp_val(8'(n), 8'(exp));
   endtask : pause

   initial
   begin
      repeat (16) @(posedge clock);
      #1;
      rst_n = 1'b1;
      t_regs();
      t_light();
      t_near();
      t_persist();
      pause(1'b1, 1'b0, 8'h00);
      pause(1'b1, 1'b0, 8'h02);
      pause(1'b1, 1'b1, 8'h01);
      pause(1'b0, 1'b0, 8'h03);
      give_verdict();
   end

   // Watchdog well above the roughly eight hundred cycles the sequence needs
   initial
   begin
      repeat (50000) @(posedge clock);
      err_count++;
      give_verdict();
   end
endmodule : tb_wait_and_threshold_regs
`default_nettype wire
